/* File: rtl/irq_sleep_regs.vh */
// Register offsets, field positions, reset values and timing counts of the interrupt/sleep block
`ifndef IRQ_SLEEP_REGS_VH
`define IRQ_SLEEP_REGS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_IRQ_ENABLE   8'h00
`define ADDR_FLAGS        8'h04
`define ADDR_SLEEP_CTRL   8'h08
`define ADDR_STATUS       8'h0c
`define ADDR_T2_MODE      8'h10

// ****************************************
// Field positions
// ****************************************
`define BIT_GATE          7
`define BIT_T2            5
`define BIT_SER           4
`define BIT_T1            3
`define BIT_X1            2
`define BIT_T0            1
`define BIT_X0            0
`define IE_IMPL_MASK      8'hbf
`define FLG_T2_OVF        5
`define FLG_T2_PIN        6
`define SLP_IDLE          0
`define SLP_PDOWN         1
`define T2M_CLKOUT        0
`define T2M_BAUD          1
`define IE_RESET          8'h00

// ****************************************
// Timing
// ****************************************
`define OSC_PER_MC        12
`define RESET_GRACE_MC    2
`define RESET_GRACE_CYC   (`RESET_GRACE_MC * `OSC_PER_MC / 2)

`endif

/* File: rtl/phase_gen.v */
// Machine-cycle phase generator running off the halved oscillator
`timescale 1ns/100ps
module phase_gen (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Oscillator run enable
  input  wire       osc_run,
  // Phase outputs
  output reg        state_tick_r,
  output reg  [2:0] state_idx_r
);
  reg half_r;

  // ****************************************
  // Divide-by-two, then six states per cycle
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      half_r       <= 1'b0;
      state_tick_r <= 1'b0;
      state_idx_r  <= 3'h0;
    end else if (osc_run) begin
      half_r       <= ~half_r;
      state_tick_r <= half_r;
      if (half_r)
        state_idx_r <= (state_idx_r == 3'h5) ? 3'h0 : state_idx_r + 3'h1;
    end else begin
      state_tick_r <= 1'b0;
    end
  end
endmodule // phase_gen

/* File: rtl/irq_sleep_ctrl.v */
// Interrupt enable, request forming and idle/power-down control with AHB-Lite registers
`timescale 1ns/100ps
`include "irq_sleep_regs.vh"
module irq_sleep_ctrl (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Interrupt source events (one-cycle pulses)
  input  wire        pin_irq0_input,
  input  wire        pin_irq1_input,
  input  wire        timer0_ovf_evt,
  input  wire        timer1_ovf_evt,
  input  wire        timer2_ovf_evt,
  input  wire        timer2_pin_evt,
  input  wire        serial_irq_evt,
  // Core side
  input  wire        irq_ack,
  input  wire        reti_done,
  output reg  [2:0]  irq_vector_r,
  output reg         irq_req_r,
  output reg         cpu_halt_r,
  output reg         osc_stop_r,
  output reg         ram_block_r,
  output reg         regs_init_r,
  output reg         resume_r,
  // Sleep pin states
  input  wire        ext_program,
  output reg         addr_latch_strobe_r,
  output reg         code_fetch_strobe_r,
  output reg         port0_float_r,
  output reg         port2_addr_r
);
  // ****************************************
  // Sleep sequencer state codes
  // ****************************************
  localparam ST_RUN   = 2'h0;
  localparam ST_IDLE  = 2'h1;
  localparam ST_PDOWN = 2'h2;
  localparam ST_GRACE = 2'h3;

  // ****************************************
  // Storage, decode and wiring
  // ****************************************
  reg  [7:0] interrupt_enable_mask;
  reg  [7:0] flags_r;
  reg  [1:0] t2_mode_r;
  reg  [1:0] mode_r;
  reg  [1:0] mode_nxt;
  reg  [3:0] grace_r;
  reg  [5:0] t01_pend_r;
  reg        wake_pend_r;
  reg        ph_wr_r;
  reg  [7:0] ph_addr_r;
  reg  [7:0] pend;
  reg  [2:0] vec;
  reg        any_req;
  reg        pin_wake;
  wire       state_tick;
  wire [2:0] state_idx;
  wire       mc_start;
  wire       t2_irq_src;
  wire       addr_phase;
  wire       wr_mask;
  wire       wr_flags;
  wire       wr_sleep;
  wire       wr_t2m;

  function wr_hit;
    input [7:0] a;
    begin
      wr_hit = ph_wr_r && (ph_addr_r == a);
    end
  endfunction

  function [31:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `ADDR_IRQ_ENABLE: rd_mux = {24'h0, interrupt_enable_mask};
        `ADDR_FLAGS:      rd_mux = {24'h0, flags_r};
        `ADDR_SLEEP_CTRL: rd_mux = {30'h0, mode_r == ST_PDOWN, mode_r == ST_IDLE};
        `ADDR_STATUS:     rd_mux = {28'h0, ram_block_r, irq_req_r, cpu_halt_r, osc_stop_r};
        `ADDR_T2_MODE:    rd_mux = {30'h0, t2_mode_r};
        default:          rd_mux = 32'h0;
      endcase
    end
  endfunction

  // ****************************************
  // Machine-cycle phase source
  // ****************************************
  phase_gen u_phase (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .osc_run      (mode_r != ST_PDOWN),
    .state_tick_r (state_tick),
    .state_idx_r  (state_idx)
  );

  // ****************************************
  // Decode and request forming
  // ****************************************
  assign mc_start   = state_tick && (state_idx == 3'h0);
  // Baud or clock-out use suppresses the overflow request
  assign t2_irq_src = (flags_r[`FLG_T2_OVF] && (t2_mode_r == 2'h0)) ||
                      flags_r[`FLG_T2_PIN];
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_mask    = wr_hit(`ADDR_IRQ_ENABLE);
  assign wr_flags   = wr_hit(`ADDR_FLAGS);
  assign wr_sleep   = wr_hit(`ADDR_SLEEP_CTRL);
  assign wr_t2m     = wr_hit(`ADDR_T2_MODE);

  // ****************************************
  // Bus slave: zero-wait, always OKAY
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      ph_wr_r   <= 1'b0;
      ph_addr_r <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ph_wr_r   <= addr_phase && hwrite;
      ph_addr_r <= haddr;
      if (addr_phase && !hwrite)
        hrdata <= rd_mux(haddr);
    end
  end

  // ****************************************
  // Registers and flags
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      interrupt_enable_mask <= `IE_RESET;
      flags_r    <= 8'h00;
      t2_mode_r  <= 2'h0;
    end else begin
      if (wr_mask)
        interrupt_enable_mask <= hwdata[7:0] & `IE_IMPL_MASK;
      if (wr_t2m)
        t2_mode_r <= hwdata[1:0];
      // Clears first, sets last: a new event in the same cycle wins
      if (wr_flags)
        flags_r <= flags_r & ~hwdata[7:0];
      // Pin/timer0/1/serial flags clear on acknowledge; Timer 2 flags never do
      if (irq_ack && vec != 3'h5)
        flags_r[vec] <= 1'b0;
      if (mc_start && t01_pend_r[`BIT_T0])
        flags_r[`BIT_T0] <= 1'b1;
      if (mc_start && t01_pend_r[`BIT_T1])
        flags_r[`BIT_T1] <= 1'b1;
      if (pin_irq0_input)
        flags_r[`BIT_X0] <= 1'b1;
      if (pin_irq1_input)
        flags_r[`BIT_X1] <= 1'b1;
      if (serial_irq_evt)
        flags_r[`BIT_SER] <= 1'b1;
      if (timer2_ovf_evt)
        flags_r[`FLG_T2_OVF] <= 1'b1;
      if (timer2_pin_evt)
        flags_r[`FLG_T2_PIN] <= 1'b1;
    end
  end

  // ****************************************
  // Timer 0/1 overflow hold-off
  // ****************************************
  // Timer 0/1 flags wait for the next machine cycle to be seen
  always @(posedge clk) begin
    if (sys_rst) begin
      t01_pend_r <= 6'h00;
    end else begin
      if (mc_start)
        t01_pend_r <= 6'h00;
      if (timer0_ovf_evt)
        t01_pend_r[`BIT_T0] <= 1'b1;
      if (timer1_ovf_evt)
        t01_pend_r[`BIT_T1] <= 1'b1;
    end
  end

  // ****************************************
  // Request priority and gating
  // ****************************************
  always @* begin
    pend = 8'h00;
    pend[`BIT_X0]  = flags_r[`BIT_X0];
    pend[`BIT_T0]  = flags_r[`BIT_T0];
    pend[`BIT_X1]  = flags_r[`BIT_X1];
    pend[`BIT_T1]  = flags_r[`BIT_T1];
    pend[`BIT_SER] = flags_r[`BIT_SER];
    pend[`BIT_T2]  = t2_irq_src;
    pend = pend & interrupt_enable_mask & 8'h3f;
    any_req = interrupt_enable_mask[`BIT_GATE] && (pend != 8'h00);
    pin_wake = interrupt_enable_mask[`BIT_GATE] &&
               ((flags_r[`BIT_X0] && interrupt_enable_mask[`BIT_X0]) ||
                (flags_r[`BIT_X1] && interrupt_enable_mask[`BIT_X1]));
    vec = 3'h0;
    if (pend[0])      vec = 3'h0;
    else if (pend[1]) vec = 3'h1;
    else if (pend[2]) vec = 3'h2;
    else if (pend[3]) vec = 3'h3;
    else if (pend[4]) vec = 3'h4;
    else              vec = 3'h5;
  end

  // ****************************************
  // Sleep mode sequencer
  // ****************************************
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      ST_RUN: begin
        if (wr_sleep && hwdata[`SLP_PDOWN])
          mode_nxt = ST_PDOWN;
        else if (wr_sleep && hwdata[`SLP_IDLE])
          mode_nxt = ST_IDLE;
      end
      ST_IDLE:  if (any_req) mode_nxt = ST_RUN;
      ST_PDOWN: if (pin_wake) mode_nxt = ST_RUN;
      ST_GRACE: mode_nxt = ST_GRACE;
      default:  mode_nxt = ST_RUN;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      mode_r      <= ST_RUN;
      wake_pend_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      if (mode_r != ST_RUN && mode_nxt == ST_RUN)
        wake_pend_r <= 1'b1;
      else if (reti_done)
        wake_pend_r <= 1'b0;
    end
  end

  // ****************************************
  // Core-side and pin outputs
  // ****************************************
  // A grace window after reset-from-idle would need the pre-reset mode;
  // the reset here is synchronous, so the window is raised from the last mode seen.
  reg [1:0] last_mode_r;
  always @(posedge clk) begin
    last_mode_r <= sys_rst ? last_mode_r : mode_r;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      irq_vector_r        <= 3'h0;
      irq_req_r           <= 1'b0;
      cpu_halt_r          <= 1'b0;
      osc_stop_r          <= 1'b0;
      ram_block_r         <= 1'b0;
      regs_init_r         <= 1'b1;
      resume_r            <= 1'b0;
      addr_latch_strobe_r <= 1'b1;
      code_fetch_strobe_r <= 1'b1;
      port0_float_r       <= 1'b0;
      port2_addr_r        <= 1'b0;
    end else begin
      irq_vector_r <= vec;
      irq_req_r    <= any_req;
      cpu_halt_r   <= (mode_nxt == ST_IDLE) || (mode_nxt == ST_PDOWN);
      osc_stop_r   <= (mode_nxt == ST_PDOWN);
      regs_init_r  <= 1'b0;
      resume_r     <= wake_pend_r && reti_done;
      // Ports stay live while RAM is fenced off
      if (last_mode_r == ST_IDLE && regs_init_r)
        ram_block_r <= 1'b1;
      else if (grace_r == `RESET_GRACE_CYC - 1)
        ram_block_r <= 1'b0;
      addr_latch_strobe_r <= (mode_nxt != ST_PDOWN);
      code_fetch_strobe_r <= (mode_nxt != ST_PDOWN);
      port0_float_r <= (mode_nxt != ST_RUN) && ext_program;
      port2_addr_r  <= (mode_nxt == ST_IDLE) && ext_program;
    end
  end

  // ****************************************
  // Reset grace window counter
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst)
      grace_r <= 4'h0;
    else if (ram_block_r)
      grace_r <= grace_r + 4'h1;
    else
      grace_r <= 4'h0;
  end
endmodule // irq_sleep_ctrl

/* File: testbench/irq_sleep_chk.sv */
// Port assertions for the interrupt enable and sleep block
`timescale 1ns/100ps
module irq_sleep_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Watched ports
  input wire logic       hsel,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       irq_ack,
  input wire logic       reti_done,
  input wire logic       irq_req_r,
  input wire logic [2:0] irq_vector_r,
  input wire logic       cpu_halt_r,
  input wire logic       osc_stop_r,
  input wire logic       ram_block_r,
  input wire logic       resume_r,
  input wire logic       addr_latch_strobe_r,
  input wire logic       code_fetch_strobe_r,
  input wire logic       port0_float_r,
  input wire logic       port2_addr_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_pd_dark: assert property (osc_stop_r |-> !addr_latch_strobe_r && !code_fetch_strobe_r)
    else $error("strobes high in power-down");
  a_run_lit: assert property (!osc_stop_r |-> addr_latch_strobe_r && code_fetch_strobe_r)
    else $error("strobes low outside power-down");
  a_pd_halts: assert property (osc_stop_r |-> cpu_halt_r)
    else $error("oscillator stopped but core running");
  a_p2_idle: assert property (port2_addr_r |-> cpu_halt_r && !osc_stop_r)
    else $error("port 2 address outside idle");
  a_p0_sleep: assert property (port0_float_r |-> cpu_halt_r)
    else $error("port 0 floats while running");
  a_t2_kept: assert property (irq_ack && irq_req_r && irq_vector_r == 3'h5 && !hsel |=> irq_req_r)
    else $error("timer 2 request dropped by vectoring");
  a_ram_grace: assert property ($rose(ram_block_r) |-> ram_block_r[*8] ##[1:12] !ram_block_r)
    else $error("ram block window wrong length");
  a_resume_src: assert property (resume_r |-> $past(reti_done))
    else $error("resume without return");
  a_vec_legal: assert property (irq_req_r |-> irq_vector_r <= 3'h5)
    else $error("vector out of range");
endmodule // irq_sleep_chk

/* File: testbench/core_model.sv */
// CPU core stand-in that takes vectors and returns from service
`timescale 1ns/100ps
module core_model #(
  parameter int ACK_DLY = 2
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Request side
  input  wire logic       irq_req_r,
  input  wire logic [2:0] irq_vector_r,
  input  wire logic       serve,
  // Answers
  output logic            irq_ack,
  output logic            reti_done,
  output logic [2:0]      last_vec,
  output int              ack_count
);
  initial begin
    irq_ack = 0;
    reti_done = 0;
    last_vec = 0;
    ack_count = 0;
  end
  always begin
    @(posedge clk);
    if (!sys_rst && serve && irq_req_r === 1'b1) begin
      repeat (ACK_DLY) @(posedge clk);
      last_vec <= irq_vector_r;
      irq_ack <= 1;
      ack_count <= ack_count + 1;
      @(posedge clk);
      irq_ack <= 0;
      repeat (4) @(posedge clk);
      reti_done <= 1;
      @(posedge clk);
      reti_done <= 0;
      // Timer 2 flags wait for the service to clear them
      while (serve && irq_req_r === 1'b1 && irq_vector_r == last_vec) @(posedge clk);
    end
  end
endmodule // core_model

/* File: testbench/tb.sv */
// Top testbench for the interrupt enable and sleep block
`timescale 1ns/100ps
module tb;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic        hsel = 0;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [6:0]  evt = 0;
  logic        ext_program = 1;
  logic        serve = 0;
  logic [31:0] q;
  wire  [31:0] hrdata;
  wire  [2:0]  irq_vector_r, last_vec;
  wire         hreadyout, hresp, irq_ack, reti_done, irq_req_r, cpu_halt_r, osc_stop_r;
  wire         ram_block_r, regs_init_r, resume_r, als, cfs, p0f, p2a;
  int          errors = 0;
  int          cmp_count = 0;
  int          acks, a0, n, e;
  always #50 clk = ~clk;
  irq_sleep_ctrl irq_sleep_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_irq0_input(evt[0]),
    .timer0_ovf_evt(evt[1]), .pin_irq1_input(evt[2]), .timer1_ovf_evt(evt[3]),
    .serial_irq_evt(evt[4]), .timer2_ovf_evt(evt[5]), .timer2_pin_evt(evt[6]),
    .irq_ack(irq_ack), .reti_done(reti_done), .irq_vector_r(irq_vector_r),
    .irq_req_r(irq_req_r), .cpu_halt_r(cpu_halt_r), .osc_stop_r(osc_stop_r),
    .ram_block_r(ram_block_r), .regs_init_r(regs_init_r), .resume_r(resume_r),
    .ext_program(ext_program), .addr_latch_strobe_r(als), .code_fetch_strobe_r(cfs),
    .port0_float_r(p0f), .port2_addr_r(p2a));
  core_model core_model_inst (.clk(clk), .sys_rst(sys_rst), .irq_req_r(irq_req_r),
    .irq_vector_r(irq_vector_r), .serve(serve), .irq_ack(irq_ack), .reti_done(reti_done),
    .last_vec(last_vec), .ack_count(acks));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task pulse(input int i);
    @(posedge clk);
    evt[i] <= 1;
    @(posedge clk);
    evt[i] <= 0;
  endtask
  task wreq(input logic v);
    for (n = 0; n < 40 && irq_req_r !== v; n++) @(posedge clk);
    chk(irq_req_r, v);
  endtask
  task t_regs;
    bus(0, 8'h00, 0);
    chk(q, 32'h0);
    chk({als, cfs, cpu_halt_r, osc_stop_r}, 4'hc);
    bus(1, 8'h00, 32'hbf);
    bus(0, 8'h00, 0);
    chk(q, 32'hbf);
    bus(0, 8'h20, 0);
    chk(q, 32'h0);
  endtask
  task t_sources;
    for (int i = 0; i < 7; i++) begin
      e = (i < 6) ? i : 5;
      bus(1, 8'h00, 1 << e);
      pulse(i);
      repeat (16) @(posedge clk);
      chk(irq_req_r, 0);
      bus(1, 8'h04, 1 << i);
      bus(1, 8'h00, 8'h80 | (1 << e));
      pulse(i);
      wreq(1);
      chk(n <= ((i == 1 || i == 3) ? 14 : 2), 1);
      chk(irq_vector_r, e);
      a0 = acks;
      serve <= 1;
      for (n = 0; n < 20 && acks == a0; n++) @(posedge clk);
      chk(last_vec, e);
      if (i >= 5) begin
        repeat (3) @(posedge clk);
        chk(irq_req_r, 1);
        bus(1, 8'h04, 1 << i);
      end
      wreq(0);
      serve <= 0;
      repeat (8) @(posedge clk);
    end
  endtask
  task t_t2mode;
    for (int m = 1; m < 3; m++) begin
      bus(1, 8'h10, m);
      bus(1, 8'h00, 8'ha0);
      pulse(5);
      repeat (16) @(posedge clk);
      chk(irq_req_r, 0);
      pulse(6);
      wreq(1);
      bus(1, 8'h04, 8'h60);
      bus(1, 8'h10, 0);
      wreq(0);
    end
  endtask
  task t_idle;
    bus(1, 8'h00, 8'h90);
    bus(1, 8'h08, 1);
    repeat (2) @(posedge clk);
    chk({cpu_halt_r, osc_stop_r, als, cfs, p0f, p2a}, 6'h2f);
    pulse(4);
    for (n = 0; n < 20 && cpu_halt_r !== 0; n++) @(posedge clk);
    chk(cpu_halt_r, 0);
    serve <= 1;
    for (n = 0; n < 30 && resume_r !== 1; n++) @(posedge clk);
    chk(resume_r, 1);
    serve <= 0;
    bus(0, 8'h00, 0);
    chk(q, 32'h90);
  endtask
  task t_pdown;
    bus(1, 8'h00, 8'h91);
    bus(1, 8'h08, 2);
    repeat (2) @(posedge clk);
    chk({cpu_halt_r, osc_stop_r, als, cfs, p0f, p2a}, 6'h32);
    pulse(4);
    repeat (20) @(posedge clk);
    chk(osc_stop_r, 1);
    pulse(0);
    for (n = 0; n < 30 && osc_stop_r !== 0; n++) @(posedge clk);
    chk(osc_stop_r, 0);
    bus(0, 8'h00, 0);
    chk(q, 32'h91);
    serve <= 1;
    wreq(0);
    serve <= 0;
    repeat (8) @(posedge clk);
  endtask
  task t_rst_idle;
    bus(1, 8'h08, 1);
    repeat (2) @(posedge clk);
    sys_rst <= 1;
    @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    chk(regs_init_r, 1);
    for (n = 0; n < 4 && ram_block_r !== 1; n++) @(posedge clk);
    chk(ram_block_r, 1);
    bus(0, 8'h00, 0);
    chk(q, 32'h0);
    for (n = 0; n < 30 && ram_block_r !== 0; n++) @(posedge clk);
    chk(ram_block_r, 0);
  endtask
  task tally_and_finish;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    t_regs;
    t_sources;
    t_t2mode;
    t_idle;
    t_pdown;
    t_rst_idle;
    tally_and_finish;
  end
  // Whole run needs under a thousand cycles
  initial begin
    #2000000;
    errors++;
    tally_and_finish;
  end
endmodule // tb
bind irq_sleep_ctrl irq_sleep_chk irq_sleep_chk_inst (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
  .hreadyout(hreadyout), .hresp(hresp), .irq_ack(irq_ack), .reti_done(reti_done),
  .irq_req_r(irq_req_r), .irq_vector_r(irq_vector_r), .cpu_halt_r(cpu_halt_r),
  .osc_stop_r(osc_stop_r), .ram_block_r(ram_block_r), .resume_r(resume_r),
  .addr_latch_strobe_r(addr_latch_strobe_r), .code_fetch_strobe_r(code_fetch_strobe_r),
  .port0_float_r(port0_float_r), .port2_addr_r(port2_addr_r));
